// *** src/ledf_defs.vh ***
// Shared constants for the LED driver fault and alert logic.
`ifndef LEDF_DEFS_VH
`define LEDF_DEFS_VH

// =============================================================
// Status bit positions inside one channel nibble.
// =============================================================
`define LEDF_STS_OV      0
`define LEDF_STS_OPEN    1
`define LEDF_STS_SHORT   2
`define LEDF_STS_OC      3
// Bit offset of the second channel's nibble in the status byte.
`define LEDF_CH2_BASE    4
// Reset value of every status flag.
`define LEDF_STS_RESET   4'h0

// =============================================================
// Positions of the raw per-channel inputs in the sampled vector.
// =============================================================
`define LEDF_IN_PWM      0
`define LEDF_IN_OVER     1
`define LEDF_IN_FBREG    2
`define LEDF_IN_SENSELOW 3
`define LEDF_IN_SHORT    4
`define LEDF_IN_OC       5
`define LEDF_IN_WIDTH    6

// =============================================================
// Address formation.
// =============================================================
`define LEDF_ADDR_PREFIX 3'h6
`define LEDF_TRIT_LOW    2'h0
`define LEDF_TRIT_HIGH   2'h1
`define LEDF_TRIT_FLOAT  2'h2

// =============================================================
// Timing.
// =============================================================
// Reference clock rate in MHz.
`define LEDF_REF_MHZ     250
// Nominal switching frequency in kHz.
`define LEDF_SW_KHZ      1000
// Reference cycles per half switching period.
`define LEDF_SW_HALF_CYC ((`LEDF_REF_MHZ * 1000) / (2 * `LEDF_SW_KHZ))
// Switching periods of short-load blanking after a channel starts.
`define LEDF_BLANK_TICKS 4'h8
// Cycles to wait after reset before the address straps are caught.
`define LEDF_STRAP_WAIT  2'h3

`endif

// *** src/ledf_channel.v ***
// One LED channel: input sampling, fault flags, gate drive and threshold scaling.
`timescale 1ns/1ns
`default_nettype none
`include "ledf_defs.vh"

module ledf_channel (
   input  wire       ref_clk,
   input  wire       reset,
   input  wire [5:0] rawIn,
   input  wire       runEnable,
   input  wire       chipFault,
   input  wire       statusRead,
   input  wire       startTick,
   input  wire [7:0] dimCode,
   input  wire [7:0] thrCtrl,
   output wire [3:0] statusNibble,
   output wire       condAny,
   output wire       pwmRise,
   output wire       switchEnable,
   output wire       lowQuiescent,
   output wire       disconnectGate,
   output wire [7:0] senseThreshold
);

   // =============================================================
   // Input synchroniser.
   // =============================================================
   reg  [5:0] syncAQ;        // First stage, read only by the second stage.
   reg  [5:0] syncBQ;        // Second stage, safe for logic.
   reg        pwmLastQ;      // Previous sampled dimming level.
   reg  [3:0] flagQ;         // Latched fault flags.
   reg  [3:0] blankCntQ;     // Blanking period counter.
   reg        startedQ;      // Channel has passed start-up blanking.
   reg        switchEnQ;     // Power switching allowed.
   reg        gateQ;         // Disconnect gate level, high means off.
   reg        lowQuiescentQ; // Sense bias currents reduced.
   reg  [7:0] thrQ;          // Scaled current-sense threshold.
   wire       pwmLvl;
   wire [3:0] condNow;
   wire       faultOff;
   wire [8:0] dimPlus;
   wire [16:0] prod;

   // Two flip-flops for every asynchronous comparator and pin input.
   always @(posedge ref_clk) begin
      if (reset) begin
         syncAQ   <= 6'h00;
         syncBQ   <= 6'h00;
         pwmLastQ <= 1'b0;
      end else begin
         syncAQ   <= rawIn;
         syncBQ   <= syncAQ;
         pwmLastQ <= syncBQ[`LEDF_IN_PWM];
      end
   end

   assign pwmLvl  = syncBQ[`LEDF_IN_PWM];
   assign pwmRise = pwmLvl & ~pwmLastQ;

   // =============================================================
   // Fault conditions and flags.
   // =============================================================
   assign condNow[`LEDF_STS_OV]    = syncBQ[`LEDF_IN_OVER];
   assign condNow[`LEDF_STS_OPEN]  = syncBQ[`LEDF_IN_FBREG] & syncBQ[`LEDF_IN_SENSELOW];
   assign condNow[`LEDF_STS_SHORT] = syncBQ[`LEDF_IN_SHORT] & startedQ;
   assign condNow[`LEDF_STS_OC]    = syncBQ[`LEDF_IN_OC];
   assign condAny  = |condNow;
   // Overvoltage and short both stop switching and open the load switch.
   assign faultOff = condNow[`LEDF_STS_OV] | condNow[`LEDF_STS_SHORT]
                   | flagQ[`LEDF_STS_OV] | flagQ[`LEDF_STS_SHORT];

   // A flag sets on its condition and clears on a status read only once the
   // condition is gone; a condition present in the read cycle wins.
   always @(posedge ref_clk) begin
      if (reset) begin
         flagQ <= `LEDF_STS_RESET;
      end else begin
         flagQ <= condNow | (flagQ & ~{4{statusRead}});
      end
   end

   // Blanking hides short detection for a few switching periods after start.
   always @(posedge ref_clk) begin
      if (reset) begin
         blankCntQ <= 4'h0;
         startedQ  <= 1'b0;
      end else if (!startedQ) begin
         if (!switchEnQ) begin
            blankCntQ <= 4'h0;
         end else if (startTick) begin
            blankCntQ <= blankCntQ + 4'h1;
            if (blankCntQ == `LEDF_BLANK_TICKS - 4'h1) begin
               startedQ <= 1'b1;
            end
         end
      end
   end

   // =============================================================
   // Switching enable, gate drive and quiescent control.
   // =============================================================
   // The gate is the inverse of the dimming input, forced off when not running, on a chip fault, an overvoltage or a short.
   always @(posedge ref_clk) begin
      if (reset) begin
         switchEnQ     <= 1'b0;
         gateQ         <= 1'b1;
         lowQuiescentQ <= 1'b1;
      end else begin
         switchEnQ     <= runEnable & pwmLvl & ~chipFault & ~faultOff;
         gateQ         <= ~pwmLvl | ~runEnable | chipFault | faultOff;
         lowQuiescentQ <= ~pwmLvl;
      end
   end

   // =============================================================
   // Threshold scaling by (code + 1) / 256.
   // =============================================================
   assign dimPlus = {1'b0, dimCode} + 9'h001;
   assign prod    = {9'h0, thrCtrl} * {8'h0, dimPlus};

   // The product is at most 255 * 256, so bits 15 to 8 hold the result.
   always @(posedge ref_clk) begin
      if (reset) begin
         thrQ <= 8'h00;
      end else begin
         thrQ <= prod[15:8];
      end
   end

   assign statusNibble   = flagQ;
   assign switchEnable   = switchEnQ;
   assign lowQuiescent   = lowQuiescentQ;
   assign disconnectGate = gateQ;
   assign senseThreshold = thrQ;

endmodule
`default_nettype wire

// *** src/ledf_fault_alert.v ***
// Top of the LED driver fault, alert, address and sync-pin logic.
`timescale 1ns/1ns
`default_nettype none
`include "ledf_defs.vh"

// Behaviour
// - Alert asserts on any of six faults.
// - Alert holds until all faults gone and released.
// - Low dimming input stops switching, gate off.
// - Gate drive is inverse of dimming input.
// - Voltage loop with low sense sets open-load.
// - Feedback overvoltage stops channel, flags, gate off.
// - Feedback short stops channel, flags, gate off.
// - Clock-out enable drives switching clock on sync.
// - Address pins decode as low, high, float.
// - Data line only pulled low or released.
// - Per-channel code scales threshold by (code+1)/256.
// - Open-load flags at status bits 1, 5.
// - Short-load flags at status bits 2, 6.
// - Idle after reset until dimming command arrives, or dimming input rises outside bus mode.
// - Target address is 110 plus four pin bits.
module ledf_fault_alert (
   input  wire       ref_clk,
   input  wire       reset,
   input  wire       ch1DimPwmIn,
   input  wire       ch1FbOverIn,
   input  wire       ch1FbRegulatingIn,
   input  wire       ch1SenseLowIn,
   input  wire       ch1FbShortIn,
   input  wire       ch1OverCurrentIn,
   input  wire       ch2DimPwmIn,
   input  wire       ch2FbOverIn,
   input  wire       ch2FbRegulatingIn,
   input  wire       ch2SenseLowIn,
   input  wire       ch2FbShortIn,
   input  wire       ch2OverCurrentIn,
   input  wire       supplyUvIn,
   input  wire       thermalShdnIn,
   input  wire       addrSelectAHigh,
   input  wire       addrSelectALow,
   input  wire       addrSelectBHigh,
   input  wire       addrSelectBLow,
   input  wire       syncClockPinIn,
   output wire       syncClockPinOut,
   output wire       syncClockPinOeN,
   input  wire       clockOutEnable,
   input  wire       readActive,
   input  wire       readBit,
   output wire       sdaOut,
   output wire       sdaOeN,
   input  wire       pwmCommandStrobe,
   input  wire       statusRead,
   input  wire [7:0] ch1AnalogDimCode,
   input  wire [7:0] ch2AnalogDimCode,
   input  wire [7:0] ch1ThresholdCtrl,
   input  wire [7:0] ch2ThresholdCtrl,
   output wire       ch1DisconnectGate,
   output wire       ch2DisconnectGate,
   output wire       ch1SwitchEnable,
   output wire       ch2SwitchEnable,
   output wire       ch1LowQuiescent,
   output wire       ch2LowQuiescent,
   output wire [7:0] ch1SenseThreshold,
   output wire [7:0] ch2SenseThreshold,
   output wire [7:0] statusFlags,
   output wire       supplyUvFlag,
   output wire       thermalFlag,
   output wire       alertOut,
   output wire       alertOeN,
   output wire [6:0] targetAddr,
   output wire       i2cMode,
   output wire       running
);

   // =============================================================
   // Declarations.
   // =============================================================
   reg  [6:0]  chipSyncAQ;     // First synchroniser stage of chip inputs.
   reg  [6:0]  chipSyncBQ;     // Second synchroniser stage of chip inputs.
   reg         syncLastQ;      // Previous sync pin level for edge finding.
   reg  [1:0]  strapWaitQ;     // Wait after reset before catching straps.
   reg         strapValidQ;    // Straps have been caught.
   reg  [3:0]  addrLowQ;       // Four address bits from the pins.
   reg         i2cModeQ;       // Any address pin not grounded.
   reg         runQ;           // Operation started.
   reg  [1:0]  chipFlagQ;      // Latched undervoltage and thermal flags.
   reg         alertOeNQ;      // Alert enable, low while pulling down.
   reg         sdaOeNQ;        // Data line enable, low while pulling down.
   reg  [7:0]  divCntQ;        // Oscillator half-period counter.
   reg         swClkQ;         // Internal switching clock.
   reg         tickQ;          // One-cycle pulse at each rising clock edge.
   reg         pinOutQ;        // Registered sync pin drive level.
   reg         pinOeNQ;        // Registered sync pin enable.
   wire [1:0]  tritA;
   wire [1:0]  tritB;
   wire [3:0]  tritSum;
   wire [1:0]  chipCond;
   wire        syncRise;
   wire        chipFault;
   wire [11:0] chRaw;
   wire [7:0]  chStatus;
   wire [1:0]  chCond;
   wire [1:0]  chRise;
   wire [1:0]  chSwEn;
   wire [1:0]  chLowQ;
   wire [1:0]  chGate;
   wire [15:0] chThr;
   wire [15:0] chDim;
   wire [15:0] chCtrl;

   // =============================================================
   // Chip input synchroniser: faults, address comparators, sync pin.
   // =============================================================
   always @(posedge ref_clk) begin
      if (reset) begin
         chipSyncAQ <= 7'h00;
         chipSyncBQ <= 7'h00;
         syncLastQ  <= 1'b0;
      end else begin
         chipSyncAQ <= {syncClockPinIn, addrSelectBLow, addrSelectBHigh,
                        addrSelectALow, addrSelectAHigh, thermalShdnIn, supplyUvIn};
         chipSyncBQ <= chipSyncAQ;
         syncLastQ  <= chipSyncBQ[6];
      end
   end

   assign chipCond = chipSyncBQ[1:0];
   assign syncRise = chipSyncBQ[6] & ~syncLastQ;

   // =============================================================
   // Address straps and operating mode.
   // =============================================================
   // A pin reading neither high nor low is floating.
   assign tritA = chipSyncBQ[2] ? `LEDF_TRIT_HIGH :
                  chipSyncBQ[3] ? `LEDF_TRIT_LOW : `LEDF_TRIT_FLOAT;
   assign tritB = chipSyncBQ[4] ? `LEDF_TRIT_HIGH :
                  chipSyncBQ[5] ? `LEDF_TRIT_LOW : `LEDF_TRIT_FLOAT;
   // Nine pin combinations map onto the values 0 to 8.
   assign tritSum = {1'b0, tritA, 1'b0} + {2'b00, tritA} + {2'b00, tritB};

   // Straps are caught once, a few cycles after reset release.
   always @(posedge ref_clk) begin
      if (reset) begin
         strapWaitQ  <= 2'h0;
         strapValidQ <= 1'b0;
         addrLowQ    <= 4'h0;
         i2cModeQ    <= 1'b0;
      end else if (!strapValidQ) begin
         if (strapWaitQ == `LEDF_STRAP_WAIT) begin
            strapValidQ <= 1'b1;
            addrLowQ    <= tritSum;
            i2cModeQ    <= (tritA != `LEDF_TRIT_LOW) | (tritB != `LEDF_TRIT_LOW);
         end else begin
            strapWaitQ <= strapWaitQ + 2'h1;
         end
      end
   end

   // In bus mode only a dimming command starts operation; otherwise a rising
   // dimming input does.
   always @(posedge ref_clk) begin
      if (reset) begin
         runQ <= 1'b0;
      end else if (strapValidQ && !runQ) begin
         runQ <= i2cModeQ ? pwmCommandStrobe : (|chRise);
      end
   end

   // =============================================================
   // Switching oscillator and sync pin.
   // =============================================================
   // An external sync edge starts a new period when the pin is an input.
   always @(posedge ref_clk) begin
      if (reset) begin
         divCntQ <= 8'h00;
         swClkQ  <= 1'b0;
         tickQ   <= 1'b0;
      end else if (!clockOutEnable && syncRise) begin
         divCntQ <= 8'h00;
         swClkQ  <= 1'b1;
         tickQ   <= 1'b1;
      end else if (divCntQ == `LEDF_SW_HALF_CYC - 1) begin
         divCntQ <= 8'h00;
         swClkQ  <= ~swClkQ;
         tickQ   <= ~swClkQ;
      end else begin
         divCntQ <= divCntQ + 8'h01;
         tickQ   <= 1'b0;
      end
   end

   // The pin carries the clock out only while the enable is set.
   always @(posedge ref_clk) begin
      if (reset) begin
         pinOutQ <= 1'b0;
         pinOeNQ <= 1'b1;
      end else begin
         pinOutQ <= swClkQ;
         pinOeNQ <= ~clockOutEnable;
      end
   end

   // =============================================================
   // Channels.
   // =============================================================
   assign chRaw  = {ch2OverCurrentIn, ch2FbShortIn, ch2SenseLowIn, ch2FbRegulatingIn,
                    ch2FbOverIn, ch2DimPwmIn,
                    ch1OverCurrentIn, ch1FbShortIn, ch1SenseLowIn, ch1FbRegulatingIn,
                    ch1FbOverIn, ch1DimPwmIn};
   assign chDim  = {ch2AnalogDimCode, ch1AnalogDimCode};
   assign chCtrl = {ch2ThresholdCtrl, ch1ThresholdCtrl};
   assign chipFault = |chipCond | |chipFlagQ;

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : gChan
         ledf_channel uChan (
            .ref_clk        (ref_clk),
            .reset          (reset),
            .rawIn          (chRaw[ch*6 +: 6]),
            .runEnable      (runQ),
            .chipFault      (chipFault),
            .statusRead     (statusRead),
            .startTick      (tickQ),
            .dimCode        (chDim[ch*8 +: 8]),
            .thrCtrl        (chCtrl[ch*8 +: 8]),
            .statusNibble   (chStatus[ch*4 +: 4]),
            .condAny        (chCond[ch]),
            .pwmRise        (chRise[ch]),
            .switchEnable   (chSwEn[ch]),
            .lowQuiescent   (chLowQ[ch]),
            .disconnectGate (chGate[ch]),
            .senseThreshold (chThr[ch*8 +: 8])
         );
      end
   endgenerate

   // =============================================================
   // Chip flags, alert and data line.
   // =============================================================
   // Chip flags latch like channel flags: read clears only once gone.
   always @(posedge ref_clk) begin
      if (reset) begin
         chipFlagQ <= 2'h0;
      end else begin
         chipFlagQ <= chipCond | (chipFlagQ & ~{2{statusRead}});
      end
   end

   // The alert pulls low while any condition or latched flag remains.
   always @(posedge ref_clk) begin
      if (reset) begin
         alertOeNQ <= 1'b1;
      end else begin
         alertOeNQ <= ~(|chCond | |chStatus | chipFault);
      end
   end

   // Read data is only ever pulled low; a one releases the line.
   always @(posedge ref_clk) begin
      if (reset) begin
         sdaOeNQ <= 1'b1;
      end else begin
         sdaOeNQ <= ~(readActive & ~readBit);
      end
   end

   assign statusFlags       = chStatus;
   assign supplyUvFlag      = chipFlagQ[0];
   assign thermalFlag       = chipFlagQ[1];
   assign alertOut          = 1'b0;
   assign alertOeN          = alertOeNQ;
   assign sdaOut            = 1'b0;
   assign sdaOeN            = sdaOeNQ;
   assign syncClockPinOut   = pinOutQ;
   assign syncClockPinOeN   = pinOeNQ;
   assign targetAddr        = {`LEDF_ADDR_PREFIX, addrLowQ};
   assign i2cMode           = i2cModeQ;
   assign running           = runQ;
   assign ch1DisconnectGate = chGate[0];
   assign ch2DisconnectGate = chGate[1];
   assign ch1SwitchEnable   = chSwEn[0];
   assign ch2SwitchEnable   = chSwEn[1];
   assign ch1LowQuiescent   = chLowQ[0];
   assign ch2LowQuiescent   = chLowQ[1];
   assign ch1SenseThreshold = chThr[7:0];
   assign ch2SenseThreshold = chThr[15:8];

endmodule
`default_nettype wire

// *** tb/ledf_fault_alert_assertions.sv ***
// Concurrent checks on the LED driver top's outputs.
`timescale 1ns/1ns
`default_nettype none
module ledf_fault_alert_chk (
   input wire logic       ref_clk,
   input wire logic       reset,
   input wire logic       ch1DimPwmIn,
   input wire logic       ch1FbOverIn,
   input wire logic       ch1FbRegulatingIn,
   input wire logic       ch1SenseLowIn,
   input wire logic       ch2OverCurrentIn,
   input wire logic       readActive,
   input wire logic       readBit,
   input wire logic       statusRead,
   input wire logic       clockOutEnable,
   input wire logic [7:0] ch1AnalogDimCode,
   input wire logic [7:0] ch1ThresholdCtrl,
   input wire logic       sdaOeN,
   input wire logic       syncClockPinOeN,
   input wire logic       ch1DisconnectGate,
   input wire logic       ch1SwitchEnable,
   input wire logic       ch1LowQuiescent,
   input wire logic [7:0] ch1SenseThreshold,
   input wire logic [7:0] statusFlags,
   input wire logic       supplyUvFlag,
   input wire logic       thermalFlag,
   input wire logic       alertOeN
);
   // =========================================================
   // Helper logic and clocking.
   // =========================================================
   // Control times code plus one; the top byte is the threshold.
   logic [16:0] prod1;
   assign prod1 = ch1ThresholdCtrl * ({1'b0, ch1AnalogDimCode} + 9'h001);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   // =========================================================
   // Properties.
   // =========================================================
   property p_sda; 1'b1 |=> sdaOeN == !($past(readActive) && !$past(readBit)); endproperty
   a_sda: assert property (p_sda) else $error("Data line enable is wrong.");
   property p_thr; 1'b1 |=> ch1SenseThreshold == $past(prod1[15:8]); endproperty
   a_thr: assert property (p_thr) else $error("Threshold scaling is wrong.");
   property p_dimlow;
      !ch1DimPwmIn [*3] |=> ch1DisconnectGate && !ch1SwitchEnable && ch1LowQuiescent;
   endproperty
   a_dimlow: assert property (p_dimlow) else $error("Low dimming did not stop.");
   property p_ov; ch1FbOverIn [*3] |=> statusFlags[0] && ch1DisconnectGate && !ch1SwitchEnable;
   endproperty
   a_ov: assert property (p_ov) else $error("Overvoltage not handled.");
   property p_open; (ch1FbRegulatingIn && ch1SenseLowIn) [*3] |=> statusFlags[1]; endproperty
   a_open: assert property (p_open) else $error("Open load flag missing.");
   property p_oc; ch2OverCurrentIn [*3] |=> statusFlags[7] ##1 !alertOeN; endproperty
   a_oc: assert property (p_oc) else $error("Overcurrent alert missing.");
   property p_hold; statusFlags[0] && !statusRead |=> statusFlags[0]; endproperty
   a_hold: assert property (p_hold) else $error("Flag dropped without read.");
   property p_alert; (|statusFlags || supplyUvFlag || thermalFlag) |=> !alertOeN; endproperty
   a_alert: assert property (p_alert) else $error("Alert released early.");
   property p_sync; 1'b1 |=> syncClockPinOeN == !$past(clockOutEnable); endproperty
   a_sync: assert property (p_sync) else $error("Sync pin drive is wrong.");
   // Main scenarios reached.
   c_short: cover property (statusFlags[2]);
   c_sync: cover property (!syncClockPinOeN);
   c_run: cover property (!ch1DisconnectGate && ch1SwitchEnable);
endmodule
bind ledf_fault_alert ledf_fault_alert_chk chk (.*);
`default_nettype wire

// *** tb/ledf_mcu_model.sv ***
// Bus controller model: sends dimming commands, reads status.
`timescale 1ns/1ns
`default_nettype none
module ledf_mcu_model (
   input  wire logic       ref_clk,
   input  wire logic [7:0] statusFlags,
   input  wire logic       sdaLine,
   output var  logic       pwmCommandStrobe,
   output var  logic       statusRead,
   output var  logic       readActive,
   output var  logic       readBit,
   output var  logic [7:0] readByte
);
   // Quiet bus at time zero.
   initial begin
      {pwmCommandStrobe, statusRead, readActive, readBit} = 4'h1;
      readByte = 8'h00;
   end
   // One-cycle dimming command; in bus mode the device stays idle until it sees this.
   task automatic send_pwm();
      @(posedge ref_clk);
      pwmCommandStrobe <= 1'b1;
      @(posedge ref_clk);
      pwmCommandStrobe <= 1'b0;
   endtask
   // Shifts the status byte out MSB first and rebuilds it from the line.
   task automatic read_status();
      for (int i = 7; i >= 0; i--) begin
         @(posedge ref_clk);
         readActive <= 1'b1;
         readBit <= statusFlags[i];
         repeat (2) @(posedge ref_clk);
         #1 readByte[i] = sdaLine;
      end
      @(posedge ref_clk);
      readActive <= 1'b0;
      statusRead <= 1'b1;
      @(posedge ref_clk);
      statusRead <= 1'b0;
   endtask
endmodule
`default_nettype wire

// *** tb/test_ledf_fault_alert.sv ***
// Self-checking bench for the LED driver fault top.
`timescale 1ns/1ns
`default_nettype none
module test_ledf_fault_alert;
   // Clocks, reset and design inputs.
   logic ref_clk, reset, linkClk, clockOutEnable, supplyUvIn, thermalShdnIn;
   logic ch1DimPwmIn, ch1FbOverIn, ch1FbRegulatingIn, ch1SenseLowIn, ch1FbShortIn, ch1OverCurrentIn;
   logic ch2DimPwmIn, ch2FbOverIn, ch2FbRegulatingIn, ch2SenseLowIn, ch2FbShortIn, ch2OverCurrentIn;
   logic addrSelectAHigh, addrSelectALow, addrSelectBHigh, addrSelectBLow;
   logic [7:0] ch1AnalogDimCode, ch2AnalogDimCode, ch1ThresholdCtrl, ch2ThresholdCtrl;
   // Design outputs and bus model signals.
   wire syncClockPinOut, syncClockPinOeN, sdaOut, sdaOeN, alertOut, alertOeN, i2cMode, running;
   wire ch1DisconnectGate, ch2DisconnectGate, ch1SwitchEnable, ch2SwitchEnable;
   wire ch1LowQuiescent, ch2LowQuiescent, supplyUvFlag, thermalFlag, syncClockPinIn;
   wire pwmCommandStrobe, statusRead, readActive, readBit, sdaLine;
   wire [7:0] ch1SenseThreshold, ch2SenseThreshold, statusFlags, readByte;
   wire [6:0] targetAddr;
   // Bench state; the table holds the status byte each fault kind should latch.
   int n_mismatch = 0, num_checks = 0, seed = 77, k, w;
   logic v;
   logic [7:0] a, b;
   logic [16:0] p, q;
   logic [7:0] expQ [$];
   logic [7:0] expTab [6] = '{8'h04, 8'h01, 8'h02, 8'h80, 8'h00, 8'h00};
   // Data line has a pull-up; the sync pin carries whichever party drives it.
   assign sdaLine = sdaOeN ? 1'b1 : sdaOut;
   assign syncClockPinIn = syncClockPinOeN ? linkClk : syncClockPinOut;
   ledf_fault_alert DUT (.*);
   ledf_mcu_model mcu (.*);
   // Reference clock and an unrelated 64 ns link clock.
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   initial begin
      linkClk = 1'b0;
      #7;
      forever #32 linkClk = ~linkClk;
   end
   // Counts and reports one comparison.
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Waits n edges, then lets their updates settle.
   task automatic wait_n(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // Raises or drops one fault kind at a clock edge.
   task automatic set_fault(input int f, input logic lv);
      @(posedge ref_clk);
      case (f)
         0: ch1FbShortIn <= lv;
         1: ch1FbOverIn <= lv;
         2: {ch1FbRegulatingIn, ch1SenseLowIn} <= {2{lv}};
         3: ch2OverCurrentIn <= lv;
         4: supplyUvIn <= lv;
         default: thermalShdnIn <= lv;
      endcase
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Each rebuilt status byte is compared with the oldest expected note.
   always @(posedge ref_clk) begin
      if (statusRead === 1'b1) begin
         check(readByte, expQ.pop_front());
      end
   end
   // Cuts a hang short.
   initial begin
      #100000;
      n_mismatch++;
      give_verdict();
   end
   // Main sequence.
   initial begin
      reset = 1'b1;
      clockOutEnable = 1'b0;
      {ch1OverCurrentIn, ch1FbShortIn, ch1SenseLowIn, ch1FbRegulatingIn, ch1FbOverIn} = 5'h00;
      {ch2OverCurrentIn, ch2FbShortIn, ch2SenseLowIn, ch2FbRegulatingIn, ch2FbOverIn} = 5'h00;
      {ch1DimPwmIn, ch2DimPwmIn, supplyUvIn, thermalShdnIn} = 4'hc;
      {addrSelectAHigh, addrSelectALow, addrSelectBHigh, addrSelectBLow} = 4'h8;
      {ch1AnalogDimCode, ch2AnalogDimCode, ch1ThresholdCtrl, ch2ThresholdCtrl} = 32'h0;
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      wait_n(20);
      check({1'b0, targetAddr}, 8'h65);
      check(i2cMode, 1'b1);
      check({running, ch1DisconnectGate, ch2DisconnectGate}, 8'h03);
      $display("Test idle done");
      mcu.send_pwm();
      wait_n(4);
      check({running, ch1DisconnectGate, ch1SwitchEnable, ch2SwitchEnable}, 8'h0b);
      @(posedge ref_clk);
      ch1DimPwmIn <= 1'b0;
      wait_n(4);
      check({ch1DisconnectGate, ch1SwitchEnable, ch1LowQuiescent}, 8'h05);
      @(posedge ref_clk);
      ch1DimPwmIn <= 1'b1;
      $display("Test start done");
      for (k = 0; k < 8; k++) begin
         a = (k == 0) ? 8'hff : 8'($random(seed));
         b = (k == 0) ? 8'hff : 8'($random(seed));
         @(posedge ref_clk);
         ch1AnalogDimCode <= a;
         ch1ThresholdCtrl <= b;
         ch2AnalogDimCode <= b;
         ch2ThresholdCtrl <= a;
         wait_n(2);
         p = b * ({1'b0, a} + 9'h001);
         q = a * ({1'b0, b} + 9'h001);
         check(ch1SenseThreshold, p[15:8]);
         check(ch2SenseThreshold, q[15:8]);
      end
      // Lets the short-load blanking run out.
      wait_n(2100);
      for (k = 0; k < 6; k++) begin
         set_fault(k, 1'b1);
         wait_n(6);
         check(alertOeN, 1'b0);
         check({supplyUvFlag, thermalFlag}, 8'({k == 4, k == 5}));
         check(ch1DisconnectGate, (k != 2) && (k != 3));
         expQ.push_back(expTab[k]);
         mcu.read_status();
         wait_n(2);
         check(statusFlags, expTab[k]);
         set_fault(k, 1'b0);
         wait_n(6);
         check(alertOeN, 1'b0);
         expQ.push_back(expTab[k]);
         mcu.read_status();
         wait_n(4);
         check(statusFlags, 8'h00);
         check(alertOeN, 1'b1);
      end
      $display("Test faults done");
      @(posedge ref_clk);
      clockOutEnable <= 1'b1;
      wait_n(3);
      check(syncClockPinOeN, 1'b0);
      for (k = 0; k < 2; k++) begin
         v = syncClockPinOut;
         w = 0;
         while (syncClockPinOut === v && w < 300) begin
            @(negedge ref_clk);
            w++;
         end
      end
      check(w[7:0], 8'h7d);
      @(posedge ref_clk);
      clockOutEnable <= 1'b0;
      wait_n(3);
      check(syncClockPinOeN, 1'b1);
      $display("Test sync done");
      give_verdict();
   end
endmodule
`default_nettype wire
